// >>> design/masr_defines.vh
/*
 * Constants for the multiplexed converter scan and readout block:
 * register offsets, field positions, reset values, state codes and times.
 * Assumes a 100 MHz system clock and 32-bit APB data.
 */
`ifndef MASR_DEFINES_VH
`define MASR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// geometry
`define MASR_NCHAN 8
`define MASR_NAXIS 4
`define MASR_CODE_W 12
`define MASR_POS_W 16
`define MASR_CODE_MID 12'h800
`define MASR_CLK_NS 10

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define MASR_OFS_CTRL 8'h00
`define MASR_OFS_STATUS 8'h04
`define MASR_OFS_CHAN_EN 8'h08
`define MASR_OFS_RANGE 8'h0C
`define MASR_OFS_USE 8'h10
`define MASR_OFS_AXIS_MAP 8'h14
`define MASR_OFS_SCAN_CNT 8'h18
`define MASR_OFS_RESULT0 8'h20
`define MASR_OFS_RESULT7 8'h3C

////////////////////////////////////////////////////////////////////////////////
// fields
`define MASR_CTRL_RUN 0
`define MASR_ST_BUSY 0
`define MASR_ST_CHAN_LSB 1
`define MASR_ST_SLOW 4
`define MASR_ST_TIMEOUT 5
`define MASR_ST_FRESH_LSB 8
`define MASR_USE_RD_LSB 8
`define MASR_MAP_EN 3

// range codes, two bits per channel
`define MASR_RNG_BI10 2'h0
`define MASR_RNG_BI5 2'h1
`define MASR_RNG_UNI10 2'h2
`define MASR_RNG_UNI5 2'h3

////////////////////////////////////////////////////////////////////////////////
// reset values
`define MASR_RST_CTRL 1'h0
`define MASR_RST_CHAN_EN 8'hFF
`define MASR_RST_RANGE 16'h0000
`define MASR_RST_USE 16'hFF00
`define MASR_RST_MAP 16'h0000

////////////////////////////////////////////////////////////////////////////////
// times in ns and derived cycle counts
`define MASR_SETTLE_NS 1000
`define MASR_CONV_TMO_NS 20000
`define MASR_LOOP_NS 62500
`define MASR_SETTLE_CYC ((`MASR_SETTLE_NS + `MASR_CLK_NS - 1) / `MASR_CLK_NS)
`define MASR_CONV_TMO_CYC (`MASR_CONV_TMO_NS / `MASR_CLK_NS)
`define MASR_LOOP_CYC (`MASR_LOOP_NS / `MASR_CLK_NS)

////////////////////////////////////////////////////////////////////////////////
// scan states
`define MASR_S_IDLE 3'h0
`define MASR_S_PICK 3'h1
`define MASR_S_SETTLE 3'h2
`define MASR_S_START 3'h3
`define MASR_S_WAIT 3'h4
`define MASR_S_STORE 3'h5

`endif

// >>> design/masr_scan_readout.v
/*
 * Scan sequencer and result store for an eight-channel multiplexed 12-bit
 * converter, with an APB register slave and axis feedback routing.
 * Assumes the converter raises done_i after start_o and holds data_i
 * stable from at least the moment done_i rises until the next start.
 */
// Design decisions made here: the APB slave port and the register addresses.
`include "masr_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1 - One 12-bit converter is stepped across eight multiplexed channels, each with a bipolar or unipolar 10 V or 5 V range.
// R2 - Channels one to four face external inputs and five to eight read the 5 V supply, a floating node, the 7.5 V reference and ground.
// R3 - Bipolar ranges return signed results from -2048 to 2047.
// R4 - Unipolar ranges return unsigned results from 0 to 4095.
// R5 - Each channel may serve axis feedback, plain readout, or both.
// R6 - Any channel may be routed as position feedback to any axis.
// R7 - Channels are enabled one by one and the scan skips disabled ones.
// R8 - A suitable channel set refreshes each feedback channel once per fastest loop sample.
// R9 - The host reads the latest result of any of the eight channels.
// R10 - A feedback channel is an absolute position held within its range span.
// R11 - The fastest loop sample to keep up with is 62.5 us per axis.
// R12 - Each result is held until the next conversion of that channel, and a disabled channel keeps its value.
module masr_scan_readout #(
	parameter LOOP_CYC = `MASR_LOOP_CYC
) (
	// clock and reset
	input wire sys_clk_i,
	input wire reset_n_i,
	// apb slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire pready_o,
	output wire pslverr_o,
	output reg [31:0] prdata_o,
	// converter front end
	output reg [2:0] adc_mux_o,
	output reg adc_start_o,
	input wire adc_done_i,
	input wire [11:0] adc_data_i,
	// axis feedback
	output reg [63:0] axis_pos_o,
	output reg [3:0] axis_update_o
);

	////////////////////////////////////////////////////////////////////////////
	// declarations
	reg run, slow_flag, tmo_flag;
	reg [7:0] chan_en, fresh;
	reg [15:0] range_sel, use_sel, axis_map;
	reg [31:0] scan_cnt;
	reg [11:0] result [0:7];
	reg [2:0] state, chan;
	reg [15:0] wait_cnt, loop_cnt;
	reg done_q1, done_q2, done_q3;
	reg [11:0] data_q1, data_q2;
	wire done_rise, setup_ph, access_ph, wr_en, rd_en, mapped, wrap, tmo_ev;
	wire [2:0] res_idx;
	wire [2:0] next_chan;
	reg store_ev;
	reg [11:0] store_val;
	reg [31:0] next_prdata;
	reg [7:0] fresh_set, fresh_clr;
	integer k;

	////////////////////////////////////////////////////////////////////////////
	// next enabled channel after cur, wrapping; cur itself if it is the only one
	function [2:0] masr_next;
		input [2:0] cur;
		input [7:0] en;
		integer i;
		reg found;
		reg [2:0] c;
		begin
			found = 1'b0;
			masr_next = cur;
			for (i = 1; i <= `MASR_NCHAN; i = i + 1) begin
				c = cur + i[2:0];
				if (!found && en[c]) begin
					masr_next = c;
					found = 1'b1;
				end
			end
		end
	endfunction
	// raw offset-binary code to the encoding of the selected range
	function [11:0] masr_encode;
		input [11:0] raw;
		input [1:0] rng;
		begin
			// R3 - bipolar two's complement
			if (rng == `MASR_RNG_BI10 || rng == `MASR_RNG_BI5) begin
				masr_encode = raw ^ `MASR_CODE_MID;
			end else begin
				// R4 - unipolar straight binary
				masr_encode = raw;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; the second stage feeds logic, the third only the done edge detect
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			done_q1 <= 1'b0;
			done_q2 <= 1'b0;
			done_q3 <= 1'b0;
			data_q1 <= 12'h000;
			data_q2 <= 12'h000;
		end else begin
			done_q1 <= adc_done_i;
			done_q2 <= done_q1;
			done_q3 <= done_q2;
			data_q1 <= adc_data_i;
			data_q2 <= data_q1;
		end
	end
	assign done_rise = done_q2 & ~done_q3;
	////////////////////////////////////////////////////////////////////////////
	// apb decode: zero wait states, read data latched in the setup cycle
	assign setup_ph = psel_i & ~penable_i;
	assign access_ph = psel_i & penable_i;
	assign pready_o = 1'b1;
	assign res_idx = paddr_i[4:2];
	assign mapped = (paddr_i[1:0] == 2'h0) &&
		(paddr_i <= `MASR_OFS_SCAN_CNT ||
		(paddr_i >= `MASR_OFS_RESULT0 && paddr_i <= `MASR_OFS_RESULT7));
	assign pslverr_o = access_ph & ~mapped;
	assign wr_en = access_ph & pwrite_i & mapped;
	assign rd_en = access_ph & ~pwrite_i & mapped;
	// read mux
	always @* begin
		next_prdata = 32'h0000_0000;
		case (paddr_i)
			`MASR_OFS_CTRL: next_prdata[`MASR_CTRL_RUN] = run;
			`MASR_OFS_STATUS: begin
				next_prdata[`MASR_ST_BUSY] = (state != `MASR_S_IDLE);
				next_prdata[`MASR_ST_CHAN_LSB +: 3] = chan;
				next_prdata[`MASR_ST_SLOW] = slow_flag;
				next_prdata[`MASR_ST_TIMEOUT] = tmo_flag;
				next_prdata[`MASR_ST_FRESH_LSB +: 8] = fresh;
			end
			`MASR_OFS_CHAN_EN: next_prdata[7:0] = chan_en;
			`MASR_OFS_RANGE: next_prdata[15:0] = range_sel;
			`MASR_OFS_USE: next_prdata[15:0] = use_sel;
			`MASR_OFS_AXIS_MAP: next_prdata[15:0] = axis_map;
			`MASR_OFS_SCAN_CNT: next_prdata = scan_cnt;
			default: begin
				// R9 - any channel readable, sign-extended for bipolar ranges
				if (paddr_i >= `MASR_OFS_RESULT0 && paddr_i <= `MASR_OFS_RESULT7) begin
					if (range_sel[2*res_idx +: 2] == `MASR_RNG_BI10 ||
						range_sel[2*res_idx +: 2] == `MASR_RNG_BI5) begin
						next_prdata = {{20{result[res_idx][11]}}, result[res_idx]};
					end else begin
						next_prdata = {20'h00000, result[res_idx]};
					end
				end
			end
		endcase
	end

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup_ph && !pwrite_i) begin
			// refused addresses read as zero, unaligned result offsets too
			prdata_o <= mapped ? next_prdata : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers written by software
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			run <= `MASR_RST_CTRL;
			chan_en <= `MASR_RST_CHAN_EN;
			range_sel <= `MASR_RST_RANGE;
			use_sel <= `MASR_RST_USE;
			axis_map <= `MASR_RST_MAP;
		end else if (wr_en) begin
			case (paddr_i)
				`MASR_OFS_CTRL: run <= pwdata_i[`MASR_CTRL_RUN];
				// R7 - per-channel enable
				`MASR_OFS_CHAN_EN: chan_en <= pwdata_i[7:0];
				// R1 - per-channel range select
				`MASR_OFS_RANGE: range_sel <= pwdata_i[15:0];
				// R5 - feedback and readout use per channel
				`MASR_OFS_USE: use_sel <= pwdata_i[15:0];
				// R6 - any channel to any axis
				`MASR_OFS_AXIS_MAP: axis_map <= pwdata_i[15:0];
				default: run <= run;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// scan sequencer
	// R7 - disabled channels are skipped when picking the next one
	assign next_chan = masr_next(chan, chan_en);
	// a pass ends when the pick does not move forward
	assign wrap = (next_chan <= chan);
	// no done edge in time, or a done level that never drops
	assign tmo_ev = ((state == `MASR_S_WAIT && !done_rise) || (state == `MASR_S_START && done_q2)) &&
		(wait_cnt >= `MASR_CONV_TMO_CYC - 1);
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= `MASR_S_IDLE;
			chan <= 3'h7;
			adc_mux_o <= 3'h0;
			adc_start_o <= 1'b0;
			wait_cnt <= 16'h0000;
			store_ev <= 1'b0;
			store_val <= 12'h000;
		end else begin
			adc_start_o <= 1'b0;
			store_ev <= 1'b0;
			case (state)
				`MASR_S_IDLE: begin
					if (run && chan_en != 8'h00) begin
						state <= `MASR_S_PICK;
					end
				end
				`MASR_S_PICK: begin
					if (!run || chan_en == 8'h00) begin
						state <= `MASR_S_IDLE;
					end else begin
						// R1 - one converter stepped across the mux
						chan <= next_chan;
						adc_mux_o <= next_chan;
						wait_cnt <= 16'h0000;
						state <= `MASR_S_SETTLE;
					end
				end
				`MASR_S_SETTLE: begin
					// mux output must settle before sampling
					if (wait_cnt >= `MASR_SETTLE_CYC - 1) begin
						adc_start_o <= 1'b1;
						wait_cnt <= 16'h0000;
						state <= `MASR_S_START;
					end else begin
						wait_cnt <= wait_cnt + 16'h0001;
					end
				end
				`MASR_S_START: begin
					// a done level left from the last channel must drop first
					if (!done_q2) begin
						state <= `MASR_S_WAIT;
					end else if (tmo_ev) begin
						// a done stuck high would stall the scan as well
						state <= `MASR_S_PICK;
					end
					wait_cnt <= wait_cnt + 16'h0001;
				end
				`MASR_S_WAIT: begin
					if (done_rise) begin
						store_val <= masr_encode(data_q2, range_sel[2*chan +: 2]);
						store_ev <= 1'b1;
						state <= `MASR_S_STORE;
					end else if (wait_cnt >= `MASR_CONV_TMO_CYC - 1) begin
						// a dead converter must not stall the scan
						state <= `MASR_S_PICK;
					end else begin
						wait_cnt <= wait_cnt + 16'h0001;
					end
				end
				`MASR_S_STORE: state <= `MASR_S_PICK;
				default: state <= `MASR_S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// result store
	// R12 - overwritten only by a new conversion of the same channel
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (k = 0; k < `MASR_NCHAN; k = k + 1) begin
				result[k] <= 12'h000;
			end
		end else if (store_ev) begin
			result[chan] <= store_val;
		end
	end
	// fresh flags for readout channels; a new result beats a clearing read
	always @* begin
		fresh_set = 8'h00;
		fresh_clr = 8'h00;
		if (store_ev && use_sel[`MASR_USE_RD_LSB + chan]) begin
			fresh_set[chan] = 1'b1;
		end
		if (rd_en && paddr_i >= `MASR_OFS_RESULT0) begin
			fresh_clr[res_idx] = 1'b1;
		end
	end
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fresh <= 8'h00;
		end else begin
			fresh <= (fresh & ~fresh_clr) | fresh_set;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// scan pace monitor against the fastest loop sample
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			loop_cnt <= 16'h0000;
			slow_flag <= 1'b0;
			tmo_flag <= 1'b0;
			scan_cnt <= 32'h0000_0000;
		end else begin
			// R8 - a full pass slower than the loop sample is flagged
			// R11 - limit is one loop sample period
			// a pass is complete once the last channel has ended, not at the first pick
			if ((state == `MASR_S_STORE || tmo_ev) && wrap) begin
				loop_cnt <= 16'h0000;
				scan_cnt <= scan_cnt + 32'h0000_0001;
			end else if (state != `MASR_S_IDLE && loop_cnt != 16'hFFFF) begin
				loop_cnt <= loop_cnt + 16'h0001;
			end else if (state == `MASR_S_IDLE) begin
				loop_cnt <= 16'h0000;
			end
			// set wins over a write-one-to-clear
			if (state != `MASR_S_IDLE && loop_cnt == LOOP_CYC[15:0]) begin
				slow_flag <= 1'b1;
			end else if (wr_en && paddr_i == `MASR_OFS_STATUS && pwdata_i[`MASR_ST_SLOW]) begin
				slow_flag <= 1'b0;
			end
			if (tmo_ev) begin
				tmo_flag <= 1'b1;
			end else if (wr_en && paddr_i == `MASR_OFS_STATUS && pwdata_i[`MASR_ST_TIMEOUT]) begin
				tmo_flag <= 1'b0;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// axis feedback routing
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			axis_pos_o <= 64'h0000_0000_0000_0000;
			axis_update_o <= 4'h0;
		end else begin
			for (k = 0; k < `MASR_NAXIS; k = k + 1) begin
				axis_update_o[k] <= 1'b0;
				// R6 - routing ignores channel number order
				// R5 - only channels marked for feedback drive an axis
				if (store_ev && axis_map[4*k + `MASR_MAP_EN] &&
					axis_map[4*k +: 3] == chan && use_sel[chan]) begin
					axis_update_o[k] <= 1'b1;
					// R10 - absolute value, bounded by the 12-bit span
					if (range_sel[2*chan +: 2] == `MASR_RNG_BI10 ||
						range_sel[2*chan +: 2] == `MASR_RNG_BI5) begin
						axis_pos_o[16*k +: 16] <= {{4{store_val[11]}}, store_val};
					end else begin
						axis_pos_o[16*k +: 16] <= {4'h0, store_val};
					end
				end
			end
		end
	end
	// R2 - channels 4..7 (zero based) are the internal test points; no special logic
endmodule

// >>> tb/masr_scan_monitor.sv
/* port checks for the scan readout block.
   assumes it is bound onto every masr_scan_readout instance. */
module masr_scan_monitor #(
	parameter LOOP_CYC = 6250
) (
	// clock and reset
	input wire sys_clk_i,
	input wire reset_n_i,
	// apb slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire pready_o,
	input wire pslverr_o,
	input wire [31:0] prdata_o,
	// converter and axes
	input wire [2:0] adc_mux_o,
	input wire adc_start_o,
	input wire adc_done_i,
	input wire [11:0] adc_data_i,
	input wire [63:0] axis_pos_o,
	input wire [3:0] axis_update_o
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!reset_n_i);
////////////////////////////////////////////////////////////////////////////////
logic [7:0] since_mux;
logic [2:0] last_mux;
// cycles since the mux moved, saturating so a lone channel never wraps
always @(posedge sys_clk_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		since_mux <= 8'hFF;
		last_mux <= 3'h0;
	end else begin
		last_mux <= adc_mux_o;
		since_mux <= (adc_mux_o != last_mux) ? 8'h00 : (since_mux == 8'hFF ? 8'hFF : since_mux + 8'h01);
	end
end
// each axis field is a zero- or sign-extended 12-bit code
function automatic logic span_ok(input logic [63:0] p);
	span_ok = 1'b1;
	for (int k = 0; k < 4; k++)
		if (p[16*k+12 +: 4] != 4'h0 && p[16*k+12 +: 4] != {4{p[16*k+11]}})
			span_ok = 1'b0;
endfunction
////////////////////////////////////////////////////////////////////////////////
start_pulse_a: assert property (adc_start_o |=> !adc_start_o) else $error("start wider than one cycle");
settle_time_a: assert property (adc_start_o |-> since_mux >= 8'h5F) else $error("start before settling");
mux_hold_a: assert property (adc_start_o |=> $stable(adc_mux_o)[*4]) else $error("mux moved in conversion");
pready_high_a: assert property (pready_o) else $error("pready low");
bad_addr_a: assert property (psel_i && penable_i && paddr_i[1:0] != 2'h0 |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
	else $error("unaligned access not refused");
upd_pulse_a: assert property (|axis_update_o |=> axis_update_o == 4'h0) else $error("update wider than one cycle");
pos_change_a: assert property ($changed(axis_pos_o) |-> |axis_update_o) else $error("position moved silently");
upd_source_a: assert property (|axis_update_o |-> adc_done_i && $past(adc_done_i, 3)) else $error("update without result");
pos_span_a: assert property (|axis_update_o |-> span_ok(axis_pos_o)) else $error("position outside span");
// main scenarios reached
cover property (axis_update_o[0] && axis_update_o[3]);
cover property (psel_i && penable_i && pslverr_o);
cover property (adc_start_o && adc_mux_o == 3'h7);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind masr_scan_readout masr_scan_monitor #(.LOOP_CYC(LOOP_CYC)) i_masr_scan_monitor (.sys_clk_i, .reset_n_i,
	.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .prdata_o,
	.adc_mux_o, .adc_start_o, .adc_done_i, .adc_data_i, .axis_pos_o, .axis_update_o);

// >>> tb/masr_adc_model.sv
/* behavioural multiplexed converter with one code per channel.
   assumes start is a one-cycle pulse with the mux already settled. */
module masr_adc_model (
	// clock
	input wire sys_clk_i,
	// control from the scan block
	input wire [2:0] adc_mux_i,
	input wire adc_start_i,
	// sensor codes and pacing
	input wire [95:0] codes_i,
	input wire slow_i,
	input wire dead_i,
	// result
	output logic adc_done_o,
	output logic [11:0] adc_data_o
);
timeunit 1ns;
timeprecision 1ps;
logic busy = 1'b0;
logic [5:0] wait_cnt = 6'h00;
logic [2:0] ch = 3'h0;
initial adc_done_o = 1'b0;
initial adc_data_o = 12'hA5A;
////////////////////////////////////////////////////////////////////////////////
// one 12-bit code per start
// bus toggles until done so a stale value never passes for a result
always @(posedge sys_clk_i) begin
	if (adc_start_i) begin
		busy <= 1'b1;
		ch <= adc_mux_i;
		wait_cnt <= slow_i ? 6'h28 : 6'h03;
		adc_done_o <= 1'b0;
		adc_data_o <= ~adc_data_o;
	end else if (busy) begin
		adc_data_o <= ~adc_data_o;
		if (wait_cnt != 6'h00) begin
			wait_cnt <= wait_cnt - 6'h01;
		end else if (!dead_i) begin
			// a dead converter stays busy and never raises done
			busy <= 1'b0;
			adc_done_o <= 1'b1;
			adc_data_o <= codes_i[12*ch +: 12];
		end
	end
end
endmodule

// >>> tb/masr_scan_readout_bench.sv
/* self-checking bench for the scan readout block.
   assumes the converter model answers every start while dead is low. */
module masr_scan_readout_bench;
timeunit 1ns;
timeprecision 1ps;
logic sys_clk_i = 1'b0;
logic reset_n_i = 1'b0;
logic psel_i = 1'b0;
logic penable_i = 1'b0;
logic pwrite_i = 1'b0;
logic [7:0] paddr_i = 8'h00;
logic [31:0] pwdata_i = 32'h0;
logic [95:0] codes = 96'h0;
logic slow = 1'b0;
logic dead = 1'b0;
wire pready_o, pslverr_o, adc_start_o, adc_done_i;
wire [31:0] prdata_o;
wire [2:0] adc_mux_o;
wire [11:0] adc_data_i;
wire [63:0] axis_pos_o;
wire [3:0] axis_update_o;
int n_fail = 0;
int cmp_count = 0;
logic [31:0] rd;
logic err;
// short loop limit keeps the slow flag reachable in a short run
masr_scan_readout #(.LOOP_CYC(300)) i_masr_scan_readout (.sys_clk_i, .reset_n_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .prdata_o, .adc_mux_o, .adc_start_o,
	.adc_done_i, .adc_data_i, .axis_pos_o, .axis_update_o);
masr_adc_model i_masr_adc_model (.sys_clk_i, .adc_mux_i(adc_mux_o), .adc_start_i(adc_start_o),
	.codes_i(codes), .slow_i(slow), .dead_i(dead), .adc_done_o(adc_done_i), .adc_data_o(adc_data_i));
// 100 MHz clock
initial forever #5 sys_clk_i = ~sys_clk_i;
////////////////////////////////////////////////////////////////////////////////
task end_of_test;
	$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
	if (n_fail == 0 && cmp_count > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
	cmp_count++;
	if (seen !== exp) begin
		n_fail++;
		$display("[FAIL] %s expected %h seen %h", what, exp, seen);
	end
endtask
// one transfer, held until pready is sampled high
task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
	int n;
	@(posedge sys_clk_i);
	psel_i <= 1'b1;
	penable_i <= 1'b0;
	pwrite_i <= wr;
	paddr_i <= addr;
	pwdata_i <= data;
	@(posedge sys_clk_i);
	penable_i <= 1'b1;
	n = 0;
	do begin
		@(posedge sys_clk_i);
		n++;
	end while (pready_o !== 1'b1 && n < 16);
	rd = prdata_o;
	err = pslverr_o;
	psel_i <= 1'b0;
	penable_i <= 1'b0;
	if (n >= 16) begin
		n_fail++;
		end_of_test();
	end
endtask
// poll the pass counter until k more passes are done
task wait_pass(input int k);
	logic [31:0] c0;
	int n;
	apb(1'b0, 8'h18, 32'h0);
	c0 = rd;
	n = 0;
	do begin
		apb(1'b0, 8'h18, 32'h0);
		n++;
	end while (rd < c0 + k && n < 2000);
	if (n >= 2000) begin
		n_fail++;
		end_of_test();
	end
endtask
// signed for bipolar codes, plain for unipolar
function automatic logic [31:0] exp_res(input logic [11:0] raw, input logic [1:0] rng);
	exp_res = rng[1] ? {20'h00000, raw} : {{21{~raw[11]}}, raw[10:0]};
endfunction
////////////////////////////////////////////////////////////////////////////////
// reset values and refused addresses
task t_reset;
	logic [7:0] a [6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h40};
	logic [31:0] e [6] = '{32'h0, 32'hFF, 32'h0, 32'hFF00, 32'h0, 32'h0};
	for (int i = 0; i < 6; i++) begin
		apb(1'b0, a[i], 32'h0);
		check("reset read", rd, e[i]);
		check("reset slverr", 32'(err), 32'(i == 5));
	end
	apb(1'b0, 8'h02, 32'h0);
	check("unaligned slverr", 32'(err), 32'h1);
endtask
// channels five to eight carry supply, floating, reference and ground levels
task t_ranges;
	codes <= {12'h001, 12'hBFF, 12'h7FF, 12'hC00, 12'h000, 12'hFFF, 12'hFFF, 12'h000};
	apb(1'b1, 8'h0C, 32'hE4E4);
	apb(1'b1, 8'h00, 32'h1);
	wait_pass(2);
	for (int n = 0; n < 8; n++) begin
		apb(1'b0, 8'h20 + 8'(4 * n), 32'h0);
		check("result", rd, exp_res(codes[12*n +: 12], n[1:0]));
	end
	apb(1'b0, 8'h04, 32'h0);
	check("slow with eight channels", 32'(rd[4]), 32'h1);
endtask
// skipped channels keep results and the scan speeds up
task t_skip;
	logic [95:0] old;
	logic [31:0] c0;
	apb(1'b1, 8'h08, 32'h05);
	wait_pass(1);
	old = codes;
	codes <= {{5{12'h555}}, 12'h800, 12'h555, 12'h7FF};
	wait_pass(2);
	apb(1'b1, 8'h04, 32'h10);
	wait_pass(2);
	apb(1'b0, 8'h04, 32'h0);
	check("slow with two channels", 32'(rd[4]), 32'h0);
	for (int n = 0; n < 8; n++) begin
		apb(1'b0, 8'h20 + 8'(4 * n), 32'h0);
		check("kept", rd, exp_res((n == 0 || n == 2) ? codes[12*n +: 12] : old[12*n +: 12], n[1:0]));
	end
	apb(1'b0, 8'h18, 32'h0);
	c0 = rd;
	repeat (1500) @(posedge sys_clk_i);
	apb(1'b0, 8'h18, 32'h0);
	check("scan rate", 32'(rd - c0 >= 5), 32'h1);
endtask
// shared channel on two axes, one axis without feedback use
task t_axis;
	int n;
	logic [31:0] e;
	slow <= 1'b1;
	apb(1'b1, 8'h10, 32'hFF04);
	apb(1'b1, 8'h14, 32'hA08A);
	e = exp_res(12'h800, 2'h2);
	n = 0;
	do begin
		@(posedge sys_clk_i);
		n++;
	end while (axis_update_o[0] !== 1'b1 && n < 2000);
	check("axis updates", 32'(axis_update_o), 32'h9);
	check("axis0 pos", 32'(axis_pos_o[15:0]), 32'(e[15:0]));
	check("axis3 pos", 32'(axis_pos_o[63:48]), 32'(e[15:0]));
	check("axis1 pos", 32'(axis_pos_o[31:16]), 32'h0);
endtask
// fresh flags on a stopped scan, then a dead converter times out
task t_status;
	int n;
	logic [31:0] keep;
	apb(1'b1, 8'h00, 32'h0);
	n = 0;
	do begin
		apb(1'b0, 8'h04, 32'h0);
		n++;
	end while (rd[0] !== 1'b0 && n < 200);
	check("stopped", 32'(rd[0]), 32'h0);
	check("fresh after scan", 32'(rd[15:8]), 32'h05);
	apb(1'b0, 8'h28, 32'h0);
	keep = rd;
	check("result2", rd, 32'h800);
	apb(1'b0, 8'h04, 32'h0);
	check("fresh after read", 32'(rd[15:8]), 32'h01);
	codes <= 96'h0;
	dead <= 1'b1;
	apb(1'b1, 8'h00, 32'h1);
	n = 0;
	do begin
		apb(1'b0, 8'h04, 32'h0);
		n++;
	end while (rd[5] !== 1'b1 && n < 1500);
	check("timeout flag", 32'(rd[5]), 32'h1);
	apb(1'b0, 8'h28, 32'h0);
	check("kept on timeout", rd, keep);
	dead <= 1'b0;
	apb(1'b1, 8'h04, 32'h20);
	apb(1'b0, 8'h04, 32'h0);
	check("timeout cleared", 32'(rd[5]), 32'h0);
endtask
////////////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
	repeat (12) @(posedge sys_clk_i);
	reset_n_i <= 1'b1;
	t_reset();
	t_ranges();
	t_skip();
	t_axis();
	t_status();
	end_of_test();
end
endmodule
